// ### common/wdt_pkg.sv
// Package: register map, field positions, reset values, types for the watchdog
package wdt_pkg;
   localparam logic [5:0]  ADDR_RELOAD  = 6'h00; // byte 0x00
   localparam logic [5:0]  ADDR_VALUE   = 6'h01; // byte 0x04
   localparam logic [5:0]  ADDR_CTRL    = 6'h02; // byte 0x08
   localparam logic [5:0]  ADDR_ICLR    = 6'h03; // byte 0x0C
   localparam logic [5:0]  ADDR_RIS     = 6'h04; // byte 0x10
   localparam logic [5:0]  ADDR_MIS     = 6'h05; // byte 0x14
   localparam logic [5:0]  ADDR_LOCK    = 6'h06; // byte 0x18
   localparam logic [5:0]  ADDR_STALL   = 6'h07; // byte 0x1C
   localparam int          CTRL_INTEN   = 0;
   localparam int          CTRL_RESEN   = 1;
   localparam int          CTRL_NMI     = 2;
   localparam logic [31:0] LOCK_KEY     = 32'h1ACCE551; // Arbitrary key
   localparam logic [31:0] RELOAD_RST   = 32'hFFFFFFFF;
   localparam logic [31:0] UNMAPPED_RD  = 32'h00000000;

   typedef struct packed {
      logic        inten;
      logic        resen;
      logic        nmi;
      logic        stall;
   } wdt_cfg_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [5:0]  idx;
      logic [31:0] data;
   } wdt_req_t;
endpackage

// ### rtl/wdt_bus.sv
// Avalon-MM slave front end: one-cycle waitrequest, request decode
`timescale 1ns/1ns
module wdt_bus
   import wdt_pkg::*;
(
   input  wire logic        clk_sys,      // System clock
   input  wire logic        srst,         // Sync reset
   input  wire logic [7:0]  address,      // Byte address
   input  wire logic        read,         // Read strobe
   input  wire logic        write,        // Write strobe
   input  wire logic [31:0] writedata,    // Write data
   output logic             waitrequest,  // Stall
   output wdt_req_t         req           // One-cycle decoded request
);
   logic             wait_reg;

   // Registered stall: high while idle, low for one cycle once a request
   // has been seen, so every access takes exactly one wait cycle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wait_reg <= 1'b1;
      end else if ((read || write) && wait_reg) begin
         wait_reg <= 1'b0;
      end else begin
         wait_reg <= 1'b1;
      end
   end

   assign waitrequest = wait_reg;

   // Reads are captured in the wait cycle so data stand at acceptance
   always_comb begin
      req.wr   = write && !wait_reg;
      req.rd   = read && wait_reg;
      req.idx  = address[7:2];
      req.data = writedata;
   end
endmodule // wdt_bus

// ### rtl/wdt_counter.sv
// 32-bit down counter with load and stall
`timescale 1ns/1ns
module wdt_counter
   import wdt_pkg::*;
(
   input  wire logic        clk_sys,   // System clock
   input  wire logic        srst,      // Sync reset
   input  wire logic        load,      // Load value
   input  wire logic [31:0] load_val,  // Value to load
   input  wire logic        dec_en,    // Count enable
   output logic [31:0]      count,     // Current count
   output logic             zero       // Count at zero, counting
);
   logic [31:0] count_reg;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         count_reg <= RELOAD_RST;
      end else if (load) begin
         count_reg <= load_val;
      end else if (dec_en && count_reg != 32'h00000000) begin
         count_reg <= count_reg - 32'h00000001;
      end
   end

   assign count = count_reg;
   assign zero  = dec_en && (count_reg == 32'h00000000);
endmodule // wdt_counter

// ### rtl/wdt_top.sv
// Watchdog timer core: registers, timeout, interrupt and reset request
//
// Operation
// - Enable starts counter and arms interrupt
// - Locked: configuration writes ignored
// - Lock status readable, true when locked
// - Interrupt clear removes pending timeout
// - Raw and masked status readable
// - Type selects standard or NMI line
// - NMI still needs enable and clear
// - Reload readable, loaded at timeout
// - Reload write while running loads counter
// - Reload of zero raises interrupt immediately
// - Reset enable gates second-timeout reset
// - Running status true once enabled
// - No stall: count ignores debug halt
// - Stall: hold count during debug halt
// - 32-bit counter, value readable
// - Second timeout uncleared raises reset
// - Unlock restores configuration writes
//
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
module wdt_top
   import wdt_pkg::*;
(
   input  wire logic        clk_sys,        // 125 MHz clock
   input  wire logic        srst,           // Sync reset, active high
   input  wire logic [7:0]  avs_address,    // Byte address
   input  wire logic        avs_read,       // Read strobe
   input  wire logic        avs_write,      // Write strobe
   input  wire logic [31:0] avs_writedata,  // Write data
   output logic [31:0]      avs_readdata,   // Read data
   output logic             avs_waitrequest,// Stall
   input  wire logic        dbg_halt,       // Processor halted
   output logic             irq,            // Standard interrupt
   output logic             nmi,            // Non-maskable interrupt
   output logic             sys_rst_req     // System reset request
);
   wdt_req_t    req;
   wdt_cfg_t    cfg_reg;
   logic [31:0] reload_reg;
   logic        run_reg;
   logic        lock_reg;
   logic        ris_reg;
   logic        rst_reg;
   logic        irq_reg;
   logic        nmi_reg;
   logic [31:0] rdata_reg;
   logic [31:0] count;
   logic        zero;
   logic        load;
   logic [31:0] load_val;
   logic        dec_en;
   logic        cfg_wr;
   logic        clr;
   logic        wait_comb;

   wdt_bus u_bus (
      .clk_sys     (clk_sys),
      .srst        (srst),
      .address     (avs_address),
      .read        (avs_read),
      .write       (avs_write),
      .writedata   (avs_writedata),
      .waitrequest (wait_comb),
      .req         (req)
   );

   assign cfg_wr = req.wr && !lock_reg;
   assign clr    = req.wr && req.idx == ADDR_ICLR;

   // Counter freezes under debug halt only when stall is set
   assign dec_en = run_reg && !(cfg_reg.stall && dbg_halt);

   always_comb begin
      load     = 1'b0;
      load_val = reload_reg;
      if (cfg_wr && req.idx == ADDR_RELOAD) begin
         load     = 1'b1;
         load_val = req.data;
      end else if (cfg_wr && req.idx == ADDR_CTRL && !run_reg) begin
         load     = 1'b1;
      end else if (zero || (clr && ris_reg)) begin
         load     = 1'b1;
      end
   end

   wdt_counter u_cnt (
      .clk_sys  (clk_sys),
      .srst     (srst),
      .load     (load),
      .load_val (load_val),
      .dec_en   (dec_en),
      .count    (count),
      .zero     (zero)
   );

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         reload_reg <= RELOAD_RST;
      end else if (cfg_wr && req.idx == ADDR_RELOAD) begin
         reload_reg <= req.data;
      end
   end

   // Enable and interrupt enable are set-only until reset
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cfg_reg <= '0;
         run_reg <= 1'b0;
      end else begin
         if (cfg_wr && req.idx == ADDR_CTRL) begin
            cfg_reg.inten <= cfg_reg.inten | req.data[CTRL_INTEN];
            cfg_reg.resen <= req.data[CTRL_RESEN];
            cfg_reg.nmi   <= req.data[CTRL_NMI];
            if (req.data[CTRL_INTEN]) begin
               run_reg <= 1'b1;
            end
         end
         if (cfg_wr && req.idx == ADDR_STALL) begin
            cfg_reg.stall <= req.data[0];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         lock_reg <= 1'b0;
      end else if (req.wr && req.idx == ADDR_LOCK) begin
         lock_reg <= (req.data != LOCK_KEY);
      end
   end

   // Raw status; set beats clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ris_reg <= 1'b0;
      end else if (zero || (cfg_wr && req.idx == ADDR_RELOAD
                            && req.data == 32'h00000000 && run_reg)) begin
         ris_reg <= 1'b1;
      end else if (clr) begin
         ris_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rst_reg <= 1'b0;
      end else if (zero && ris_reg && cfg_reg.resen) begin
         rst_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         irq_reg <= 1'b0;
         nmi_reg <= 1'b0;
      end else begin
         irq_reg <= ris_reg && cfg_reg.inten && !cfg_reg.nmi;
         nmi_reg <= ris_reg && cfg_reg.inten && cfg_reg.nmi;
      end
   end

   // Captured in the wait cycle so data stand when waitrequest drops
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rdata_reg <= UNMAPPED_RD;
      end else if (req.rd) begin
         unique case (req.idx)
            ADDR_RELOAD: rdata_reg <= reload_reg;
            ADDR_VALUE:  rdata_reg <= count;
            ADDR_CTRL:   rdata_reg <= {28'h0000000, run_reg, cfg_reg.nmi,
                                       cfg_reg.resen, cfg_reg.inten};
            ADDR_RIS:    rdata_reg <= {31'h00000000, ris_reg};
            ADDR_MIS:    rdata_reg <= {31'h00000000,
                                       ris_reg & cfg_reg.inten};
            ADDR_LOCK:   rdata_reg <= {31'h00000000, lock_reg};
            ADDR_STALL:  rdata_reg <= {31'h00000000, cfg_reg.stall};
            default:     rdata_reg <= UNMAPPED_RD;
         endcase
      end
   end

   assign avs_readdata    = rdata_reg;
   assign avs_waitrequest = wait_comb;
   assign irq             = irq_reg;
   assign nmi             = nmi_reg;
   assign sys_rst_req     = rst_reg;

   // Register access and lock
   a_lock_blocks: assert property (
      @(posedge clk_sys) disable iff (srst)
      lock_reg && req.wr && req.idx == ADDR_RELOAD |=> $stable(reload_reg))
      else $error("reload changed while locked");
   a_lock_ctrl: assert property (
      @(posedge clk_sys) disable iff (srst)
      lock_reg && req.wr && req.idx == ADDR_CTRL
      |=> $stable(cfg_reg.inten) && $stable(cfg_reg.resen)
          && $stable(cfg_reg.nmi) && $stable(run_reg))
      else $error("control changed while locked");
   a_lock_stall: assert property (
      @(posedge clk_sys) disable iff (srst)
      lock_reg && req.wr && req.idx == ADDR_STALL |=> $stable(cfg_reg.stall))
      else $error("stall changed while locked");
   a_lock_flag: assert property (
      @(posedge clk_sys) disable iff (srst)
      req.wr && req.idx == ADDR_LOCK
      |=> lock_reg == ($past(req.data) != LOCK_KEY))
      else $error("lock state does not follow key");
   a_unlock_open: assert property (
      @(posedge clk_sys) disable iff (srst)
      !lock_reg && req.wr && req.idx == ADDR_RELOAD
      |=> reload_reg == $past(req.data))
      else $error("reload write lost while unlocked");
   a_lock_read: assert property (
      @(posedge clk_sys) disable iff (srst)
      req.rd && req.idx == ADDR_LOCK
      |=> avs_readdata == {31'h00000000, $past(lock_reg)})
      else $error("lock state read wrong");

   // Enable, reload and readback
   a_start_arms: assert property (
      @(posedge clk_sys) disable iff (srst)
      cfg_wr && req.idx == ADDR_CTRL && req.data[CTRL_INTEN]
      |=> run_reg && cfg_reg.inten)
      else $error("enable did not arm counter and interrupt");
   a_start_load: assert property (
      @(posedge clk_sys) disable iff (srst)
      cfg_wr && req.idx == ADDR_CTRL && !run_reg
      |=> count == reload_reg)
      else $error("counter not loaded at start");
   a_run_sticky: assert property (
      @(posedge clk_sys) disable iff (srst)
      run_reg |=> run_reg)
      else $error("running indication dropped");
   a_run_read: assert property (
      @(posedge clk_sys) disable iff (srst)
      req.rd && req.idx == ADDR_CTRL
      |=> avs_readdata[3] == $past(run_reg))
      else $error("running indication read wrong");
   a_reload_now: assert property (
      @(posedge clk_sys) disable iff (srst)
      cfg_wr && req.idx == ADDR_RELOAD
      |=> count == $past(req.data))
      else $error("reload write not loaded into counter");
   a_reload_read: assert property (
      @(posedge clk_sys) disable iff (srst)
      req.rd && req.idx == ADDR_RELOAD
      |=> avs_readdata == $past(reload_reg))
      else $error("reload value read wrong");
   a_value_read: assert property (
      @(posedge clk_sys) disable iff (srst)
      req.rd && req.idx == ADDR_VALUE
      |=> avs_readdata == $past(count))
      else $error("counter value read wrong");

   // Raw status, clear and routing
   a_zero_reload: assert property (
      @(posedge clk_sys) disable iff (srst)
      run_reg && !lock_reg && req.wr && req.idx == ADDR_RELOAD
      && req.data == 32'h00000000 |=> ris_reg)
      else $error("zero reload raised no interrupt");
   a_timeout_ris: assert property (
      @(posedge clk_sys) disable iff (srst)
      zero |=> ris_reg)
      else $error("timeout did not set raw status");
   a_ris_read: assert property (
      @(posedge clk_sys) disable iff (srst)
      req.rd && req.idx == ADDR_RIS
      |=> avs_readdata == {31'h00000000, $past(ris_reg)})
      else $error("raw status read wrong");
   a_mis_read: assert property (
      @(posedge clk_sys) disable iff (srst)
      req.rd && req.idx == ADDR_MIS
      |=> avs_readdata == {31'h00000000,
                           $past(ris_reg) & $past(cfg_reg.inten)})
      else $error("masked status read wrong");
   a_ris_clear: assert property (
      @(posedge clk_sys) disable iff (srst)
      clr && !zero |=> !ris_reg)
      else $error("raw status not removed by clear");
   a_clear_drops: assert property (
      @(posedge clk_sys) disable iff (srst)
      clr && !zero |=> ##1 !irq && !nmi)
      else $error("interrupt not removed by clear");
   a_nmi_route: assert property (
      @(posedge clk_sys) disable iff (srst)
      cfg_reg.nmi |=> !irq_reg)
      else $error("standard line driven in nmi mode");
   a_irq_raise: assert property (
      @(posedge clk_sys) disable iff (srst)
      ris_reg && cfg_reg.inten && !cfg_reg.nmi |=> irq_reg)
      else $error("standard interrupt not raised");
   a_nmi_raise: assert property (
      @(posedge clk_sys) disable iff (srst)
      ris_reg && cfg_reg.inten && cfg_reg.nmi |=> nmi_reg)
      else $error("nmi not raised");
   a_irq_masked: assert property (
      @(posedge clk_sys) disable iff (srst)
      !cfg_reg.inten |=> !irq_reg && !nmi_reg)
      else $error("interrupt raised without enable");

   // Second timeout and reset request
   a_reset_gate: assert property (
      @(posedge clk_sys) disable iff (srst)
      !cfg_reg.resen && !rst_reg |=> !rst_reg)
      else $error("reset without enable");
   a_second_out: assert property (
      @(posedge clk_sys) disable iff (srst)
      zero && ris_reg && cfg_reg.resen |=> sys_rst_req)
      else $error("second timeout gave no reset");
   a_rst_sticky: assert property (
      @(posedge clk_sys) disable iff (srst)
      rst_reg |=> rst_reg)
      else $error("reset request dropped");

   // Counter
   a_stall_hold: assert property (
      @(posedge clk_sys) disable iff (srst)
      cfg_reg.stall && dbg_halt && !load |=> $stable(count))
      else $error("count moved under debug stall");
   a_free_count: assert property (
      @(posedge clk_sys) disable iff (srst)
      run_reg && !cfg_reg.stall && !load && count != 32'h00000000
      |=> count == $past(count) - 32'h00000001)
      else $error("count did not decrement");
   a_timeout_rel: assert property (
      @(posedge clk_sys) disable iff (srst)
      zero |=> count == reload_reg)
      else $error("no reload at timeout");
   a_clear_reload: assert property (
      @(posedge clk_sys) disable iff (srst)
      clr && ris_reg |=> count == reload_reg)
      else $error("no reload at clear");

   // Bus timing: one wait cycle, read data frozen between reads
   a_one_wait: assert property (
      @(posedge clk_sys) disable iff (srst)
      (avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest)
      else $error("more than one wait cycle");
   a_wait_back: assert property (
      @(posedge clk_sys) disable iff (srst)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for two cycles");
   a_read_stands: assert property (
      @(posedge clk_sys) disable iff (srst)
      !req.rd |=> $stable(avs_readdata))
      else $error("read data moved without a read");

   c_first_to:  cover property (@(posedge clk_sys) $rose(ris_reg));
   c_nmi_fire:  cover property (@(posedge clk_sys) $rose(nmi_reg));
   c_sys_reset: cover property (@(posedge clk_sys) $rose(rst_reg));
   c_lock_drop: cover property (@(posedge clk_sys) $fell(lock_reg));
   c_int_clear: cover property (@(posedge clk_sys) $fell(ris_reg));
endmodule // wdt_top

// ### sim/wdt_cpu_model.sv
// Processor-side model: debug halt line and handler entry count
`timescale 1ns/1ns
module wdt_cpu_model (
   input  wire logic clk_sys,   // System clock
   input  wire logic halt_req,  // Bench asks for a debug halt
   input  wire logic irq,       // Standard interrupt in
   input  wire logic nmi,       // NMI in
   output logic      dbg_halt,  // Halt level to the core
   output int        n_entry    // Handler entries seen
);
   logic irq_q;
   initial begin
      dbg_halt = 1'b0;
      irq_q = 1'b0;
      n_entry = 0;
   end
   // Halt follows the request a cycle late, as a core would
   always @(posedge clk_sys) begin
      dbg_halt <= halt_req;
      irq_q <= irq | nmi;
      if (!irq_q && (irq | nmi)) n_entry <= n_entry + 1;
   end
endmodule // wdt_cpu_model

// ### sim/test_watchdog_timer_core.sv
// Self-checking bench: bus tasks and register scenarios
`timescale 1ns/1ns
module test_watchdog_timer_core
   import wdt_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        halt_req = 1'b0;
   logic        dbg_halt, irq, nmi, sys_rst_req;
   int          n_entry, n_errors = 0, tests_run = 0;
   logic [31:0] v1, v2, v3;
   always #4 clk_sys = ~clk_sys;
   wdt_top wdt_top_i (.clk_sys(clk_sys), .srst(srst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .dbg_halt(dbg_halt), .irq(irq), .nmi(nmi),
      .sys_rst_req(sys_rst_req));
   wdt_cpu_model wdt_cpu_model_i (.clk_sys(clk_sys),
      .halt_req(halt_req), .irq(irq), .nmi(nmi),
      .dbg_halt(dbg_halt), .n_entry(n_entry));
   task automatic results();
      $display("tests %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Hold the request until waitrequest is sampled low
   task automatic bus(input logic [5:0] ix, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
      int i;
      avs_address <= {ix, 2'b00};
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_sys);
         if (avs_waitrequest === 1'b0) break;
      end
      if (i == 20) begin
         chk(1'b1, 1'b0);
         results();
      end
      // Read data stand at the accepting edge
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // One idle edge keeps the next request apart
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [5:0] ix, input logic [31:0] d);
      logic [31:0] q;
      bus(ix, 1'b1, d, q);
   endtask
   task automatic rc(input logic [5:0] ix, input logic [31:0] e);
      logic [31:0] q;
      bus(ix, 1'b0, 32'h00000000, q);
      chk(q, e);
   endtask
   task automatic rd(input logic [5:0] ix, output logic [31:0] q);
      bus(ix, 1'b0, 32'h00000000, q);
   endtask
   // Bounded wait for an output: 0 irq, 1 nmi, 2 reset request
   task automatic wait_out(input int sel, input logic v, input int n);
      int i;
      logic s;
      for (i = 0; i < n; i++) begin
         @(posedge clk_sys);
         s = (sel == 0) ? irq : (sel == 1) ? nmi : sys_rst_req;
         if (s === v) break;
      end
      chk(s, v);
      if (i == n) results();
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      rc(ADDR_RELOAD, RELOAD_RST);
      rc(ADDR_VALUE, 32'hFFFFFFFF);
      rc(ADDR_LOCK, 32'h00000000);
      rc(ADDR_CTRL, 32'h00000000);
      rc(ADDR_RIS, 32'h00000000);
      rc(6'h3F, UNMAPPED_RD);
      chk(irq, 1'b0);
      $display("test reset done");
      wr(ADDR_CTRL, 32'h00000001);
      rc(ADDR_CTRL, 32'h00000009);
      wr(ADDR_RELOAD, 32'h00000800);
      rd(ADDR_VALUE, v1);
      chk(v1 <= 32'h800 && v1 > 32'h7F0, 1'b1);
      halt_req <= 1'b1;
      rd(ADDR_VALUE, v1);
      rd(ADDR_VALUE, v2);
      chk(v2 < v1, 1'b1);
      wr(ADDR_STALL, 32'h00000001);
      rd(ADDR_VALUE, v1);
      rd(ADDR_VALUE, v2);
      chk(v2, v1);
      halt_req <= 1'b0;
      // Halt drops a cycle late; let the counter move first
      repeat (3) @(posedge clk_sys);
      rd(ADDR_VALUE, v3);
      chk(v3 < v2, 1'b1);
      wr(ADDR_STALL, 32'h00000000);
      $display("test count and stall done");
      wr(ADDR_RELOAD, 32'h00000014);
      wait_out(0, 1'b1, 40);
      rc(ADDR_RIS, 32'h00000001);
      rc(ADDR_MIS, 32'h00000001);
      repeat (60) @(posedge clk_sys);
      chk(sys_rst_req, 1'b0);
      chk(n_entry, 1);
      wr(ADDR_ICLR, 32'h00000001);
      wait_out(0, 1'b0, 4);
      rc(ADDR_RELOAD, 32'h00000014);
      $display("test timeout done");
      wr(ADDR_LOCK, 32'h00000000);
      rc(ADDR_LOCK, 32'h00000001);
      wr(ADDR_RELOAD, 32'h00000005);
      rc(ADDR_RELOAD, 32'h00000014);
      wr(ADDR_CTRL, 32'h00000006);
      rc(ADDR_CTRL, 32'h00000009);
      wr(ADDR_LOCK, LOCK_KEY);
      rc(ADDR_LOCK, 32'h00000000);
      wr(ADDR_RELOAD, 32'h00007530);
      rc(ADDR_RELOAD, 32'h00007530);
      wr(ADDR_ICLR, 32'h00000001);
      $display("test lock done");
      wr(ADDR_CTRL, 32'h00000005);
      rc(ADDR_CTRL, 32'h0000000D);
      wr(ADDR_RELOAD, 32'h0000001E);
      wait_out(1, 1'b1, 60);
      chk(irq, 1'b0);
      rc(ADDR_MIS, 32'h00000001);
      wr(ADDR_ICLR, 32'h00000001);
      wait_out(1, 1'b0, 4);
      wr(ADDR_CTRL, 32'h00000007);
      wr(ADDR_RELOAD, 32'h00000000);
      wait_out(1, 1'b1, 4);
      wait_out(2, 1'b1, 10);
      $display("test nmi and reset done");
      results();
   end
endmodule // test_watchdog_timer_core
